// [thp_bit_mem.sv]
// Sixteen-entry one-bit store for the receive buffer
`timescale 1ns/1ps
module thp_bit_mem
   import thp_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic we,
   input wire logic [3:0] waddr,
   input wire logic wdata,
   input wire logic [3:0] raddr,
   output logic rdata
);
   thp_mem_t st_ff, nxt_st;

   // Read sees a write of the same cycle
   always_comb begin
      nxt_st = st_ff;
      if (we) begin
         nxt_st.mem[waddr] = wdata;
      end
      nxt_st.rd = nxt_st.mem[raddr];
      if (rst) begin
         nxt_st = '0;
      end
   end

   always_ff @(posedge clk) begin
      st_ff <= nxt_st;
   end

   assign rdata = st_ff.rd;
endmodule

// [thp_consts.svh]
// Command codes, field positions, reset values and timing of the host port
`ifndef THP_CONSTS_SVH
`define THP_CONSTS_SVH

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define THP_CLK_NS 50
`define THP_CAL_US 500
`define THP_MS_US 1000
`define THP_RECAL_S 30
`define THP_BIT_BASE 13'h010

// ---------------------------------------------------------------------------
// Command codes (upper byte of a write word; upper nibble for the wake timer)
// ---------------------------------------------------------------------------
`define THP_OP_GEN 8'h80
`define THP_OP_PWR 8'h82
`define THP_OP_TXB 8'hb8
`define THP_OP_FIFO 8'hca
`define THP_OP_SYNL 8'hce
`define THP_OP_SYNH 8'hcf
`define THP_OP_RATE 8'hc6
`define THP_OP_DUTY 8'hc8
`define THP_OP_BAT 8'hc0
`define THP_OP_WUT 4'he

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define THP_GEN_TXEN 7
`define THP_GEN_FIFOEN 6
`define THP_PWR_RX 7
`define THP_PWR_TX 5
`define THP_PWR_OSC 3
`define THP_PWR_LBD 2
`define THP_PWR_WUT 1
`define THP_FIFO_FILL 1
`define THP_FIFO_SYN16 3
`define THP_PB_TXRX 5
`define THP_PB_POR 4
`define THP_PB_OVR 3
`define THP_PB_WUT 2
`define THP_PB_EXT 1
`define THP_PB_LBD 0

// ---------------------------------------------------------------------------
// Reset values and analog scaling
// ---------------------------------------------------------------------------
`define THP_GEN_RST 8'h08
`define THP_PWR_RST 8'h08
`define THP_FIFO_RST 8'h70
`define THP_SYNC_RST 16'h2dd4
`define THP_RATE_RST 8'h23
`define THP_DUTY_RST 8'h0e
`define THP_WUT_RST 12'h196
`define THP_TX_PRELOAD 16'haaaa
`define THP_TX_FILL 8'haa
`define THP_LB_BASE_MV 12'h7d0
`define THP_LB_STEP_MV 12'h032
`define THP_HYST_MV 12'h032

`endif

// [thp_host_model.sv]
// Behavioural host serial master driving the host port
`timescale 1ns/1ps
module thp_host_model (
   output logic sck,
   output logic cs_n,
   output logic sdi,
   output logic fsel,
   input wire logic sdo
);
   // ------------------------------------------------------------------
   // Idle levels
   // ------------------------------------------------------------------
   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
      fsel = 1'b1;
   end

   // ------------------------------------------------------------------
   // One frame of n rises; read bits sampled on rises 2..n
   // ------------------------------------------------------------------
   // Mode zero, MSB first
   task automatic frame(input logic [15:0] w, input logic sel,
         input int n, input int half, output logic [15:0] rd);
      rd = 16'h0000;
      fsel = sel;
      cs_n = 1'b0;
      #200;
      for (int i = 0; i < n; i++) begin
         sdi = (i < 16) ? w[15 - i] : ~sdi;
         #half;
         if (i > 0) rd = {rd[14:0], sdo};
         sck = 1'b1;
         #half;
         sck = 1'b0;
      end
      #half;
      cs_n = 1'b1;
      // Released data line shows no stale value
      sdi = ~sdi;
      fsel = 1'b1;
      #250;
   endtask
endmodule

// [thp_host_port.sv]
// Host-facing digital core of the sub-GHz transceiver
`timescale 1ns/1ps
`include "thp_consts.svh"
module thp_host_port
   import thp_pkg::*;
#(
   parameter logic [15:0] CAL_CYC =
      16'(`THP_CAL_US * 1000 / `THP_CLK_NS),
   parameter logic [15:0] RECAL_MS = 16'(`THP_RECAL_S * 1000)
)
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic SCK,
   input wire logic CS_N,
   input wire logic SDI,
   output logic SDO,
   input wire logic MOD_DATA_SELECT_PIN,
   input wire logic EXT_INT_N,
   output logic HOST_IRQ_OUT_N,
   output logic RX_FILL_IRQ_PIN,
   input wire logic RX_BIT,
   input wire logic RX_BIT_STB,
   output logic TX_DATA,
   output logic RX_ON,
   output logic OSC_EN,
   input wire logic RC_CLK,
   input wire logic [11:0] SUPPLY_MV
);
   thp_core_t st, nxt;
   logic [15:0] lk_word;
   logic lk_wtgl, lk_ptgl, head;
   logic word_evt, pop_evt, ext_fall, rc_edge, tx_on, tx_stb;
   logic fifo_en, push, pop, ms_tick, cal_go, fill_hit, sync_hit;
   logic [5:0] ev, clr;
   logic [4:0] thr;
   logic [12:0] period;
   logic [11:0] thr_mv;

   // ------------------------------------------------------------------------
   // Serial port and receive store
   // ------------------------------------------------------------------------
   thp_spi_link u_link (
      .sck(SCK),
      .cs_n(CS_N),
      .rst(SYS_RST),
      .sdi(SDI),
      .fsel(MOD_DATA_SELECT_PIN),
      .status_word(st.snap),
      .fifo_head(head),
      .sdo(SDO),
      .word(lk_word),
      .word_tgl(lk_wtgl),
      .pop_tgl(lk_ptgl)
   );

   thp_bit_mem u_mem (
      .clk(CLK),
      .rst(SYS_RST),
      .we(push),
      .waddr(st.wr_ptr),
      .wdata(RX_BIT),
      .raddr(nxt.rd_ptr),
      .rdata(head)
   );

   // ------------------------------------------------------------------------
   // Core next state
   // ------------------------------------------------------------------------
   always_comb begin
      nxt = st;
      ev = 6'h00;
      clr = 6'h00;
      push = 1'b0;
      ms_tick = 1'b0;
      cal_go = 1'b0;
      nxt.cs1 = CS_N;
      nxt.cs2 = st.cs1;
      nxt.w1 = lk_wtgl;
      nxt.w2 = st.w1;
      nxt.w3 = st.w2;
      nxt.p1 = lk_ptgl;
      nxt.p2 = st.p1;
      nxt.p3 = st.p2;
      nxt.e1 = EXT_INT_N;
      nxt.e2 = st.e1;
      nxt.e3 = st.e2;
      nxt.m1 = MOD_DATA_SELECT_PIN;
      nxt.m2 = st.m1;
      nxt.r1 = RC_CLK;
      nxt.r2 = st.r1;
      nxt.r3 = st.r2;
      nxt.s1 = SUPPLY_MV;
      nxt.s2 = st.s1;
      word_evt = st.w2 ^ st.w3;
      pop_evt = st.p2 ^ st.p3;
      ext_fall = st.e3 & ~st.e2;
      rc_edge = st.r2 & ~st.r3;
      ev[`THP_PB_EXT] = ext_fall;

      // Snapshot frozen while the host is selected
      if (st.cs2) begin
         nxt.snap = {st.pend, st.cnt == 5'h00, 9'h000};
      end

      // Transmit shifter
      tx_on = st.gen[`THP_GEN_TXEN] & st.pwr[`THP_PWR_TX];
      period = ({5'h00, st.rate} + 13'h0001) * `THP_BIT_BASE;
      tx_stb = tx_on && (st.tx_div == period - 13'h0001);
      if (!tx_on) begin
         nxt.tx_div = 13'h0000;
         nxt.tx_bits = 3'h0;
      end else if (tx_stb) begin
         // high stage shifts out, low stage refills
         nxt.tx_div = 13'h0000;
         nxt.tx_out = st.tx_sh[15];
         nxt.tx_sh = {st.tx_sh[14:0], 1'b0};
         nxt.tx_bits = st.tx_bits + 3'h1;
         if (st.tx_bits == 3'h7) begin
            if (st.txb_full) begin
               nxt.tx_sh[7:0] = st.txb;
               nxt.txb_full = 1'b0;
               ev[`THP_PB_TXRX] = 1'b1;
            end else begin
               nxt.tx_sh[7:0] = `THP_TX_FILL;
               ev[`THP_PB_OVR] = 1'b1;
            end
         end
      end else begin
         nxt.tx_div = st.tx_div + 13'h0001;
      end
      // direct modulation when register is off
      nxt.txd = tx_on ? nxt.tx_out : st.m2;

      // Commands; settings only change here
      // nothing in sleep touches the settings
      if (word_evt) begin
         if (!lk_word[15]) begin
            // clear what the host has just read
            clr = st.snap[15:10];
         end else if (lk_word[15:12] == `THP_OP_WUT) begin
            nxt.wut = lk_word[11:0];
         end else begin
            case (lk_word[15:8])
               `THP_OP_GEN: nxt.gen = lk_word[7:0];
               `THP_OP_PWR: nxt.pwr = lk_word[7:0];
               `THP_OP_FIFO: nxt.fcfg = lk_word[7:0];
               `THP_OP_SYNL: nxt.sync[7:0] = lk_word[7:0];
               `THP_OP_SYNH: nxt.sync[15:8] = lk_word[7:0];
               `THP_OP_RATE: nxt.rate = lk_word[7:0];
               `THP_OP_DUTY: nxt.duty = lk_word[7:0];
               `THP_OP_BAT: nxt.bat = lk_word[4:0];
               `THP_OP_TXB: begin
                  nxt.txb = lk_word[7:0];
                  nxt.txb_full = 1'b1;
               end
               default: ;
            endcase
         end
      end

      // Receive buffer
      fifo_en = st.gen[`THP_GEN_FIFOEN];
      thr = {1'b0, st.fcfg[7:4]} + 5'h01;
      sync_hit = st.fcfg[`THP_FIFO_SYN16] ?
         ({st.hist[14:0], RX_BIT} == st.sync) :
         ({st.hist[6:0], RX_BIT} == st.sync[7:0]);
      if (RX_BIT_STB) begin
         nxt.hist = {st.hist[14:0], RX_BIT};
      end
      if (!(fifo_en && st.fcfg[`THP_FIFO_FILL])) begin
         nxt.filling = 1'b0;
      end else if (RX_BIT_STB) begin
         // sync bits themselves are never stored
         if (!st.filling) begin
            nxt.filling = sync_hit;
         end else if (st.cnt == 5'h10) begin
            ev[`THP_PB_OVR] = 1'b1;
         end else begin
            push = 1'b1;
         end
      end
      pop = pop_evt && (st.cnt != 5'h00);
      if (push) begin
         nxt.wr_ptr = st.wr_ptr + 4'h1;
      end
      if (pop) begin
         nxt.rd_ptr = st.rd_ptr + 4'h1;
      end
      nxt.cnt = st.cnt + {4'h0, push} - {4'h0, pop};
      fill_hit = fifo_en && (nxt.cnt >= thr);
      nxt.fill_pin = fill_hit;
      if (fill_hit && !st.fill_pin) begin
         ev[`THP_PB_TXRX] = 1'b1;
      end

      // Supply monitor
      thr_mv = `THP_LB_BASE_MV + {7'h00, st.bat} * `THP_LB_STEP_MV;
      // set below threshold, release above hysteresis
      if (!st.pwr[`THP_PWR_LBD]) begin
         nxt.low = 1'b0;
      end else if (!st.low && st.s2 < thr_mv) begin
         nxt.low = 1'b1;
         ev[`THP_PB_LBD] = 1'b1;
      end else if (st.low && st.s2 >= thr_mv + `THP_HYST_MV) begin
         nxt.low = 1'b0;
      end

      // Wake timer calibration and millisecond ticks
      if (st.cal_act) begin
         nxt.cal_tmr = st.cal_tmr + 16'h0001;
         if (rc_edge) begin
            nxt.rc_cnt = st.rc_cnt + 17'h00001;
         end
         if (st.cal_tmr == CAL_CYC - 16'h0001) begin
            nxt.cal_act = 1'b0;
            nxt.cal_cnt = st.rc_cnt[15:0];
            nxt.rc_cnt = 17'h00000;
         end
      end else if (rc_edge && st.cal_cnt != 16'h0000) begin
         if (st.rc_cnt + 17'h00001 >= {1'b0, st.cal_cnt} *
             17'(`THP_MS_US / `THP_CAL_US)) begin
            ms_tick = 1'b1;
            nxt.rc_cnt = 17'h00000;
         end else begin
            nxt.rc_cnt = st.rc_cnt + 17'h00001;
         end
      end
      if (ms_tick) begin
         nxt.recal = st.recal + 16'h0001;
         if (st.recal == RECAL_MS - 16'h0001) begin
            nxt.recal = 16'h0000;
            cal_go = 1'b1;
         end
      end
      // timer enable starts a calibration, which holds the oscillator on
      if (nxt.pwr[`THP_PWR_WUT] && !st.pwr[`THP_PWR_WUT]) begin
         cal_go = 1'b1;
      end
      if (cal_go) begin
         nxt.cal_act = 1'b1;
         nxt.cal_tmr = 16'h0000;
         nxt.rc_cnt = 17'h00000;
      end

      // Wake timer and low duty cycle receive
      case (st.wt)
         THP_WT_IDLE: begin
            if (st.pwr[`THP_PWR_WUT]) begin
               nxt.wt = THP_WT_RUN;
               nxt.wt_cnt = {15'h0000, st.wut[7:0]} << st.wut[11:8];
            end
         end
         THP_WT_RUN: begin
            if (!st.pwr[`THP_PWR_WUT]) begin
               nxt.wt = THP_WT_IDLE;
            end else if (ms_tick) begin
               if (st.wt_cnt <= 23'h000001) begin
                  ev[`THP_PB_WUT] = 1'b1;
                  nxt.wt_cnt = {15'h0000, st.wut[7:0]} << st.wut[11:8];
                  // open the receiver for a short look
                  if (st.duty[0]) begin
                     nxt.wt = THP_WT_RXWIN;
                     nxt.dc_ms = st.duty[7:1];
                  end
               end else begin
                  nxt.wt_cnt = st.wt_cnt - 23'h000001;
               end
            end
         end
         THP_WT_RXWIN: begin
            if (!st.pwr[`THP_PWR_WUT]) begin
               nxt.wt = THP_WT_IDLE;
            end else if (ms_tick) begin
               if (st.dc_ms <= 7'h01) begin
                  nxt.wt = THP_WT_RUN;
               end else begin
                  nxt.dc_ms = st.dc_ms - 7'h01;
               end
            end
         end
         default: nxt.wt = THP_WT_IDLE;
      endcase

      // any pending event drives the request low
      nxt.pend = (st.pend & ~clr) | ev;
      nxt.irq_n = ~|nxt.pend;
      nxt.osc = st.pwr[`THP_PWR_OSC] | nxt.cal_act;
      nxt.rx_on = st.pwr[`THP_PWR_RX] | (nxt.wt == THP_WT_RXWIN);

      if (SYS_RST) begin
         nxt = '0;
         {nxt.cs1, nxt.cs2, nxt.e1, nxt.e2, nxt.e3} = 5'h1f;
         nxt.gen = `THP_GEN_RST;
         nxt.pwr = `THP_PWR_RST;
         nxt.fcfg = `THP_FIFO_RST;
         nxt.sync = `THP_SYNC_RST;
         nxt.rate = `THP_RATE_RST;
         nxt.duty = `THP_DUTY_RST;
         nxt.wut = `THP_WUT_RST;
         nxt.pend[`THP_PB_POR] = 1'b1;
         nxt.osc = 1'b1;
         nxt.cal_act = 1'b1;
         nxt.wt = THP_WT_IDLE;
         nxt.tx_sh = `THP_TX_PRELOAD;
      end
   end

   always_ff @(posedge CLK) begin
      st <= nxt;
   end

   assign HOST_IRQ_OUT_N = st.irq_n;
   assign RX_FILL_IRQ_PIN = st.fill_pin;
   assign TX_DATA = st.txd;
   assign RX_ON = st.rx_on;
   assign OSC_EN = st.osc;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);

   chk_lbd_hold: assert property (
      st.low && st.pwr[`THP_PWR_LBD] && st.s2 < thr_mv + `THP_HYST_MV
      |=> st.low) else $error("low supply released inside hysteresis");
   chk_cal_end: assert property (
      st.cal_act && st.cal_tmr == CAL_CYC - 16'h0001 && !cal_go
      |=> !st.cal_act && st.cal_cnt == $past(st.rc_cnt[15:0]))
      else $error("calibration window length wrong");
   chk_cal_osc: assert property (
      st.cal_act |-> OSC_EN) else $error("oscillator off during calibration");
   chk_duty_rx: assert property (
      st.wt == THP_WT_RUN && ms_tick && st.wt_cnt <= 23'h000001 &&
      st.duty[0] && st.pwr[`THP_PWR_WUT] |=> RX_ON && st.pend[`THP_PB_WUT])
      else $error("wake expiry did not open receiver");
   chk_ext_event: assert property (
      $fell(st.e2) |=> ##1 st.pend[`THP_PB_EXT])
      else $error("external pulse not recorded");
   chk_irq_drive: assert property (
      ext_fall |=> !HOST_IRQ_OUT_N) else $error("request output not low");
   chk_status_clear: assert property (
      word_evt && !lk_word[15] && ev == 6'h00
      |=> (st.pend & $past(st.snap[15:10])) == 6'h00)
      else $error("status read left bits pending");
   chk_tx_shift: assert property (
      tx_stb |=> TX_DATA == $past(st.tx_sh[15]))
      else $error("transmit bit order wrong");
   chk_tx_direct: assert property (
      !tx_on |=> TX_DATA == $past(st.m2))
      else $error("direct modulation not passed");
   chk_fill_pin: assert property (
      fifo_en && st.cnt + {4'h0, push} >= thr + {4'h0, pop}
      |=> RX_FILL_IRQ_PIN) else $error("fill pin missed threshold");
   chk_sync_gate: assert property (
      push |-> st.filling) else $error("buffer written before sync");

   cov_status_read: cover property (word_evt && !lk_word[15]);
   cov_rx_push: cover property (push ##[1:40] pop);
   cov_wake: cover property (ev[`THP_PB_WUT]);
   cov_overrun: cover property (ev[`THP_PB_OVR]);
endmodule

// [thp_pkg.sv]
// Types shared by the transceiver host port modules
package thp_pkg;

   typedef enum logic [2:0] {
      THP_WT_IDLE = 3'b001,
      THP_WT_RUN = 3'b010,
      THP_WT_RXWIN = 3'b100
   } thp_wt_state_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic [14:0] sh;
      logic fifo_m;
      logic [15:0] out_sh;
   } thp_frame_t;

   typedef struct packed {
      logic [15:0] word;
      logic wtgl;
      logic ptgl;
   } thp_keep_t;

   typedef struct packed {
      logic [15:0] mem;
      logic rd;
   } thp_mem_t;

   typedef struct packed {
      logic cs1, cs2, w1, w2, w3, p1, p2, p3, e1, e2, e3, m1, m2, r1, r2, r3;
      logic [11:0] s1, s2;
      logic [7:0] gen, pwr, fcfg, rate, duty;
      logic [15:0] sync;
      logic [4:0] bat;
      logic [11:0] wut;
      logic [5:0] pend;
      logic [15:0] snap;
      logic irq_n;
      logic [15:0] tx_sh;
      logic [7:0] txb;
      logic txb_full;
      logic [12:0] tx_div;
      logic [2:0] tx_bits;
      logic tx_out, txd;
      logic [15:0] hist;
      logic filling;
      logic [3:0] wr_ptr, rd_ptr;
      logic [4:0] cnt;
      logic fill_pin, low, cal_act;
      logic [15:0] cal_tmr, cal_cnt, recal;
      logic [16:0] rc_cnt;
      thp_wt_state_t wt;
      logic [22:0] wt_cnt;
      logic [6:0] dc_ms;
      logic rx_on, osc;
   } thp_core_t;

endpackage

// [thp_spi_link.sv]
// Serial command port logic running on the host serial clock
`timescale 1ns/1ps
module thp_spi_link
   import thp_pkg::*;
(
   input wire logic sck,
   input wire logic cs_n,
   input wire logic rst,
   input wire logic sdi,
   input wire logic fsel,
   input wire logic [15:0] status_word,
   input wire logic fifo_head,
   output logic sdo,
   output logic [15:0] word,
   output logic word_tgl,
   output logic pop_tgl
);
   thp_frame_t fr_ff, nxt_fr;
   thp_keep_t kp_ff, nxt_kp;
   logic sdo_ff;

   always_comb begin
      nxt_fr = fr_ff;
      nxt_kp = kp_ff;
      nxt_fr.sh = {fr_ff.sh[13:0], sdi};
      if (fr_ff.cnt != 5'h10) begin
         nxt_fr.cnt = fr_ff.cnt + 5'h01;
      end
      if (fr_ff.cnt == 5'h00) begin
         // select pin low picks buffer read
         nxt_fr.fifo_m = ~fsel;
         nxt_fr.out_sh = sdi ? 16'h0000 : status_word;
      end else begin
         nxt_fr.out_sh = {fr_ff.out_sh[14:0], 1'b0};
         if (fr_ff.fifo_m) begin
            nxt_kp.ptgl = ~kp_ff.ptgl;
         end
      end
      if (fr_ff.cnt == 5'h0f && !fr_ff.fifo_m) begin
         nxt_kp.word = {fr_ff.sh, sdi};
         nxt_kp.wtgl = ~kp_ff.wtgl;
      end
   end

   // sample on rising edges while selected
   always_ff @(posedge sck or posedge cs_n) begin
      if (cs_n) begin
         fr_ff <= '0;
      end else begin
         fr_ff <= nxt_fr;
      end
   end

   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         kp_ff <= '0;
      end else begin
         kp_ff <= nxt_kp;
      end
   end

   // slow read clock keeps buffer head settled here
   always_ff @(negedge sck or posedge cs_n) begin
      if (cs_n) begin
         sdo_ff <= 1'b0;
      end else begin
         sdo_ff <= fr_ff.fifo_m ? fifo_head : fr_ff.out_sh[15];
      end
   end

   assign sdo = sdo_ff;
   assign word = kp_ff.word;
   assign word_tgl = kp_ff.wtgl;
   assign pop_tgl = kp_ff.ptgl;
endmodule

// [thp_tb.sv]
// Self-checking bench for the transceiver host port
`timescale 1ns/1ps
module tb;
   import thp_pkg::*;
   logic clk, sys_rst, sck, cs_n, sdi, sdo, fsel, ext_int_n, irq_n;
   logic fill_pin, rx_bit, rx_bit_stb, tx_data, rx_on, osc_en, rc_clk;
   logic prev;
   logic [11:0] supply_mv;
   logic [15:0] rd, n;
   int num_errors = 0;
   int tests_run = 0;
   int cycles = 0;

   // ------------------------------------------------------------------
   // Clocks and instances
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      rc_clk = 1'b0;
      forever #500 rc_clk = ~rc_clk;
   end

   thp_host_port #(.CAL_CYC(16'h0014), .RECAL_MS(16'h0003)) dut (
      .CLK(clk), .SYS_RST(sys_rst), .SCK(sck), .CS_N(cs_n), .SDI(sdi),
      .SDO(sdo), .MOD_DATA_SELECT_PIN(fsel), .EXT_INT_N(ext_int_n),
      .HOST_IRQ_OUT_N(irq_n), .RX_FILL_IRQ_PIN(fill_pin),
      .RX_BIT(rx_bit), .RX_BIT_STB(rx_bit_stb), .TX_DATA(tx_data),
      .RX_ON(rx_on), .OSC_EN(osc_en), .RC_CLK(rc_clk),
      .SUPPLY_MV(supply_mv));

   thp_host_model host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .fsel(fsel),
      .sdo(sdo));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wt(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [15:0] w);
      logic [15:0] d;
      host.frame(w, 1'b1, 16, 24, d);
      wt(6);
   endtask

   task automatic rd_status();
      host.frame(16'h0000, 1'b1, 17, 24, rd);
      wt(6);
   endtask

   task automatic send_bits(input logic [15:0] v, input int c);
      for (int i = c - 1; i >= 0; i--) begin
         @(posedge clk);
         rx_bit <= v[i];
         rx_bit_stb <= 1'b1;
         @(posedge clk);
         rx_bit_stb <= 1'b0;
      end
      wt(4);
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         num_errors++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      ext_int_n = 1'b1;
      rx_bit = 1'b0;
      rx_bit_stb = 1'b0;
      supply_mv = 12'hce4;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      wt(2);
      check("irq after reset", {15'h0, irq_n}, 16'h0000);
      check("osc after reset", {15'h0, osc_en}, 16'h0001);
      rd_status();
      check("reset status", rd, 16'h4200);
      check("irq cleared", {15'h0, irq_n}, 16'h0001);
      $display("test reset status done");

      @(posedge clk);
      ext_int_n <= 1'b0;
      repeat (4) @(posedge clk);
      ext_int_n <= 1'b1;
      wt(6);
      check("irq ext", {15'h0, irq_n}, 16'h0000);
      rd_status();
      check("ext status", rd, 16'h0a00);
      $display("test external interrupt done");

      host.frame(16'h8288, 1'b1, 15, 24, rd);
      wt(6);
      check("rx after partial", {15'h0, rx_on}, 16'h0000);
      wr(16'h8288);
      check("rx after word", {15'h0, rx_on}, 16'h0001);
      wr(16'h8208);
      $display("test command frames done");

      wr(16'hc000);
      wr(16'h820c);
      @(posedge clk);
      supply_mv <= 12'h7c6;
      wt(10);
      check("irq low supply", {15'h0, irq_n}, 16'h0000);
      rd_status();
      check("low status", rd, 16'h0600);
      @(posedge clk);
      supply_mv <= 12'h834;
      wt(10);
      rd_status();
      check("irq supply ok", {15'h0, irq_n}, 16'h0001);
      $display("test low supply done");

      wr(16'h8048);
      wr(16'hca7a);
      send_bits(16'h2dd4, 16);
      send_bits(16'h002e, 7);
      check("fill below", {15'h0, fill_pin}, 16'h0000);
      send_bits(16'h0000, 1);
      check("fill at level", {15'h0, fill_pin}, 16'h0001);
      check("irq fill", {15'h0, irq_n}, 16'h0000);
      host.frame(16'h0000, 1'b0, 9, 250, rd);
      check("buffer data", rd, 16'h005c);
      $display("test receive buffer done");

      wr(16'hc600);
      wr(16'h8088);
      wr(16'h8228);
      wt(40);
      n = 16'h0000;
      prev = tx_data;
      repeat (160) begin
         wt(1);
         if (tx_data !== prev) n++;
         prev = tx_data;
      end
      check("preamble edges", n, 16'h000a);
      $display("test transmit preamble done");

      // oscillator held on once the wake timer starts, by calibration and the oscillator power bit
      wr(16'h8208);
      rd_status();
      check("irq quiet", {15'h0, irq_n}, 16'h0001);
      wr(16'he001);
      wr(16'hc803);
      wr(16'h820a);
      check("osc with timer", {15'h0, osc_en}, 16'h0001);
      n = 16'h0000;
      repeat (300) begin
         wt(1);
         if (rx_on === 1'b1) n++;
      end
      check("duty window", {15'h0, n != 16'h0000}, 16'h0001);
      check("irq wake", {15'h0, irq_n}, 16'h0000);
      rd_status();
      check("wake status", rd, 16'h1200);
      $display("test wake timer done");
      print_verdict();
   end
endmodule
